// ### src/sico_ctrl.sv
/*
 * execution of indirect call/branch, the three return forms, interrupt
 * enable/disable and acceptance, halt/stop and no-op, with an avalon-mm
 * register slave. assumes the fetch stage offers one word per cycle at
 * programCounter and holds it until instrReady; pins are asynchronous.
 */
// The Avalon-MM interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
// Behaviour
// - indirect call pushes next address, jumps
// - jump base upper 22 bits read zero
// - plain return pops address, stack pointer up
// - skipping return also steps past next
// - interrupt return restores saved flag word
// - accepted interrupt saves the flag word
// - interrupt return always pops save stack
// - enable acts after the next instruction that does not move the pc
// - pending interrupt vectors at instruction boundary
// - request flags set even when source masked
// - disable clears master enable at once
// - stop halts clock until operand condition
// - halt waits for operand-selected condition
// - no-op only advances the program counter
`include "sico_cfg.svh"
module sico_ctrl
	import sico_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input sico_instr_type instr,
	input wire logic [`SICO_SRC_N-1:0] irqPin,
	input wire logic wakePin,
	input sico_avs_req_type avsReq,
	output logic [31:0] avsReaddata,
	output logic avsWaitrequest,
	output logic instrReady,
	output logic [`SICO_PC_W-1:0] programCounter,
	output logic [`SICO_SP_W-1:0] stackPtr,
	output logic masterIrqEnable,
	output logic [`SICO_FLAG_W-1:0] flagWord,
	output sico_mode_type powerMode,
	output logic sysClkStop
);

	logic [`SICO_PC_W-1:0] pc_r, pc_nxt, jumpBase_r, retRd, vecAddr;
	logic [`SICO_SP_W-1:0] sp_r, sp_nxt;
	logic [`SICO_ISP_W-1:0] isp_r, isp_nxt;
	logic [`SICO_FLAG_W-1:0] flag_r, flag_nxt, saveRd;
	logic [`SICO_SRC_N-1:0] req_r, req_nxt, srcEn_r, srcEn_nxt, reqSet, reqClr, vecSel;
	logic [3:0] cond_r, cond_nxt, pinSyncA_r, pinSyncB_r, pinSyncC_r, lvl_r, lvl_nxt;
	logic [3:0] wakeEvt;
	logic mie_r, mie_nxt, hold_r, hold_nxt, ready_r, clkStop_r, waitReq_r;
	logic [31:0] rdata_r, rdMux, statWord;
	sico_mode_type mode_r, mode_nxt;

	// ----------------------------------------------------------------
	// pin synchronisers and level filter
	// ----------------------------------------------------------------
	// three stages per pin; the level moves only when stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_pin
			wire pinIn = (gi == 3) ? wakePin : irqPin[gi % `SICO_SRC_N];
			assign lvl_nxt[gi] = (pinSyncB_r[gi] == pinSyncC_r[gi]) ? pinSyncC_r[gi] : lvl_r[gi];
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					pinSyncA_r[gi] <= 1'h0;
					pinSyncB_r[gi] <= 1'h0;
					pinSyncC_r[gi] <= 1'h0;
					lvl_r[gi] <= 1'h0;
				end else begin
					pinSyncA_r[gi] <= pinIn;
					pinSyncB_r[gi] <= pinSyncA_r[gi];
					pinSyncC_r[gi] <= pinSyncB_r[gi];
					lvl_r[gi] <= lvl_nxt[gi];
				end
			end
		end
	endgenerate

	// rising level on a source pin raises its request whatever its enable
	assign reqSet = lvl_nxt[`SICO_SRC_N-1:0] & ~lvl_r[`SICO_SRC_N-1:0];

	// ----------------------------------------------------------------
	// instruction decode
	// ----------------------------------------------------------------
	wire [15:0] w = instr.word;
	wire take = instr.valid && ready_r && (mode_r == MODE_RUN);
	wire isCallAr = take && (w == `SICO_OP_CALL_AR);
	wire isBrAr = take && (w == `SICO_OP_BR_AR);
	wire isRet = take && (w == `SICO_OP_RET);
	wire isRetSk = take && (w == `SICO_OP_SUBR_EXIT_SKIP_OP);
	wire isReti = take && (w == `SICO_OP_ISR_EXIT_OP);
	wire isEi = take && (w == `SICO_OP_EI);
	wire isDi = take && (w == `SICO_OP_DI);
	wire isNop = take && (w == `SICO_OP_NOP);
	wire isStop = take && (w[15:4] == `SICO_OP_STOP_HI);
	wire isHalt = take && (w[15:4] == `SICO_OP_HALT_HI);
	wire isPop = isRet || isRetSk || isReti;
	wire altPc = isCallAr || isBrAr || isPop;

	// ----------------------------------------------------------------
	// interrupt selection and acceptance
	// ----------------------------------------------------------------
	wire [`SICO_SRC_N-1:0] pend = req_r & srcEn_r;
	wire vectorGo = (mode_r == MODE_VECTOR) && (|pend);
	assign vecSel = pend & (~pend + 3'h1); // lowest pending source
	assign vecAddr = vecSel[0] ? `SICO_VEC0 : (vecSel[1] ? `SICO_VEC1 : `SICO_VEC2);
	// the instruction after an enable runs first, longer if it moved the pc
	assign hold_nxt = isEi ? 1'h1 : ((take && !altPc) ? 1'h0 : hold_r);
	assign mie_nxt = isEi ? 1'h1 : ((isDi || vectorGo) ? 1'h0 : mie_r);
	wire acceptNxt = mie_nxt && !hold_nxt && (|(req_nxt & srcEn_nxt));

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	wire busReq = avsReq.read || avsReq.write;
	wire busWr = avsReq.write && !waitReq_r;
	wire [31:0] wd = avsReq.writedata;
	wire wrJbase = busWr && (avsReq.address == `SICO_OFS_JBASE);
	wire wrIrq = busWr && (avsReq.address == `SICO_OFS_IRQ);
	wire wrFlag = busWr && (avsReq.address == `SICO_OFS_FLAG);

	// requests: write one to clear, acceptance clears its own, set wins
	assign reqClr = (wrIrq ? wd[`SICO_IRQ_REQ_LSB +: `SICO_SRC_N] : 3'h0)
		| (vectorGo ? vecSel : 3'h0);
	assign req_nxt = reqSet | (req_r & ~reqClr);
	assign srcEn_nxt = wrIrq ? wd[`SICO_SRC_N-1:0] : srcEn_r;

	// ----------------------------------------------------------------
	// program counter and stacks
	// ----------------------------------------------------------------
	always_comb begin
		pc_nxt = pc_r;
		if (vectorGo) begin
			pc_nxt = vecAddr;
		end else if (isCallAr || isBrAr) begin
			pc_nxt = jumpBase_r;
		end else if (isRet || isReti) begin
			pc_nxt = retRd;
		end else if (isRetSk) begin
			pc_nxt = retRd + 10'h001;
		end else if (take) begin
			pc_nxt = pc_r + 10'h001;
		end
	end

	// calls and acceptance push below the pointer, returns pop at it
	assign sp_nxt = (vectorGo || isCallAr) ? (sp_r - 3'h1) : (isPop ? (sp_r + 3'h1) : sp_r);
	wire retWe = vectorGo || isCallAr;
	wire [`SICO_PC_W-1:0] retWd = vectorGo ? pc_r : (pc_r + 10'h001);

	// save stack pushes on acceptance, always pops on interrupt return
	assign isp_nxt = vectorGo ? (isp_r - 2'h1) : (isReti ? (isp_r + 2'h1) : isp_r);
	assign flag_nxt = isReti ? saveRd : (wrFlag ? wd[`SICO_FLAG_W-1:0] : flag_r);

	sico_lifo #(.W(`SICO_PC_W), .AW(`SICO_SP_W)) u_retStack (
		.clk(clk),
		.we(retWe),
		.waddr(sp_r - 3'h1),
		.wdata(retWd),
		.raddr(sp_r),
		.rdata(retRd)
	);

	sico_lifo #(.W(`SICO_FLAG_W), .AW(`SICO_ISP_W)) u_saveStack (
		.clk(clk),
		.we(vectorGo),
		.waddr(isp_r - 2'h1),
		.wdata(flag_r),
		.raddr(isp_r),
		.rdata(saveRd)
	);

	// ----------------------------------------------------------------
	// mode sequencing
	// ----------------------------------------------------------------
	// release bits: sources' request flags, then the wake pin
	assign wakeEvt = {lvl_r[3], req_r};
	wire released = |(cond_r & wakeEvt);
	assign cond_nxt = (isStop || isHalt) ? w[3:0] : cond_r;

	always_comb begin
		mode_nxt = mode_r;
		case (mode_r)
			MODE_RUN: begin
				if (isStop) begin
					mode_nxt = MODE_STOP;
				end else if (isHalt) begin
					mode_nxt = MODE_HALT;
				end else if (acceptNxt) begin
					mode_nxt = MODE_VECTOR;
				end
			end
			MODE_VECTOR: begin
				mode_nxt = MODE_RUN;
			end
			MODE_HALT, MODE_STOP: begin
				if (released) begin
					mode_nxt = MODE_RUN;
				end
			end
			default: begin
				mode_nxt = MODE_RUN;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// core state registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pc_r <= `SICO_PC_RST;
			sp_r <= `SICO_SP_RST;
			isp_r <= `SICO_ISP_RST;
			flag_r <= `SICO_FLAG_RST;
			mie_r <= 1'h0;
			hold_r <= 1'h0;
			req_r <= 3'h0;
			srcEn_r <= `SICO_SRCEN_RST;
			cond_r <= `SICO_COND_RST;
			mode_r <= MODE_RUN;
			ready_r <= 1'h0;
			clkStop_r <= 1'h0;
		end else begin
			pc_r <= pc_nxt;
			sp_r <= sp_nxt;
			isp_r <= isp_nxt;
			flag_r <= flag_nxt;
			mie_r <= mie_nxt;
			hold_r <= hold_nxt;
			req_r <= req_nxt;
			srcEn_r <= srcEn_nxt;
			cond_r <= cond_nxt;
			mode_r <= mode_nxt;
			ready_r <= (mode_nxt == MODE_RUN);
			clkStop_r <= (mode_nxt == MODE_STOP);
		end
	end

	// jump base keeps ten bits; the upper 22 never exist
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			jumpBase_r <= `SICO_JBASE_RST;
		end else if (wrJbase) begin
			jumpBase_r <= wd[`SICO_PC_W-1:0];
		end
	end

	// ----------------------------------------------------------------
	// bus read data and wait handshake
	// ----------------------------------------------------------------
	always_comb begin
		statWord = 32'h0000_0000;
		statWord[`SICO_PC_W-1:0] = pc_r;
		statWord[`SICO_STAT_SP_LSB +: `SICO_SP_W] = sp_r;
		statWord[`SICO_STAT_MIE_BIT] = mie_r;
		statWord[`SICO_STAT_MODE_LSB +: 2] = mode_r;
		statWord[`SICO_STAT_COND_LSB +: 4] = cond_r;
	end

	wire [31:0] irqWord = {21'h00_0000, req_r, 5'h00, srcEn_r};
	assign rdMux = (avsReq.address == `SICO_OFS_JBASE) ? {22'h00_0000, jumpBase_r}
		: (avsReq.address == `SICO_OFS_IRQ) ? irqWord
		: (avsReq.address == `SICO_OFS_FLAG) ? {28'h000_0000, flag_r}
		: (avsReq.address == `SICO_OFS_STAT) ? statWord : 32'h0000_0000;

	// one wait cycle per access, then released for one cycle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			waitReq_r <= 1'h1;
			rdata_r <= 32'h0000_0000;
		end else begin
			waitReq_r <= !(busReq && waitReq_r);
			if (busReq && waitReq_r) begin
				rdata_r <= rdMux;
			end
		end
	end

	// outputs straight from flops
	assign avsReaddata = rdata_r;
	assign avsWaitrequest = waitReq_r;
	assign instrReady = ready_r;
	assign programCounter = pc_r;
	assign stackPtr = sp_r;
	assign masterIrqEnable = mie_r;
	assign flagWord = flag_r;
	assign powerMode = mode_r;
	assign sysClkStop = clkStop_r;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence sEiTaken;
		isEi ##1 (hold_r && !take);
	endsequence

	sequence sVectorEntry;
		(mode_r == MODE_VECTOR && |pend) ##1 (mode_r == MODE_RUN);
	endsequence

	a_call_push: assert property (
		isCallAr |=> (sp_r == $past(sp_r) - 3'h1) && (retRd == $past(pc_r) + 10'h001))
		else $error("indirect call did not push the next address");
	a_jump_bits: assert property (
		(isCallAr || isBrAr) |=> (pc_r == $past(jumpBase_r)) && (rdMux[31:10] == 22'h0 ||
			avsReq.address != `SICO_OFS_JBASE))
		else $error("indirect target not the ten-bit jump base");
	a_ret_pop: assert property (
		isRet |=> (pc_r == $past(retRd)) && (sp_r == $past(sp_r) + 3'h1))
		else $error("return did not restore address and pointer");
	a_subr_exit_skip_op_skip: assert property (
		isRetSk |=> (pc_r == $past(retRd) + 10'h001) && (sp_r == $past(sp_r) + 3'h1))
		else $error("skipping return did not step past");
	a_isr_exit_op_flags: assert property (
		isReti |=> (flag_r == $past(saveRd)) && (isp_r == $past(isp_r) + 2'h1))
		else $error("interrupt return did not restore the flag word");
	a_vec_save: assert property (
		sVectorEntry |-> (isp_r == $past(isp_r) - 2'h1) && (saveRd == $past(flag_r)) && !mie_r)
		else $error("acceptance did not save the flag word");
	a_ei_defer: assert property (
		sEiTaken |=> (mode_r != MODE_VECTOR))
		else $error("interrupt taken before the following instruction");
	a_vec_jump: assert property (
		vectorGo |=> (pc_r == $past(vecAddr)) && (sp_r == $past(sp_r) - 3'h1))
		else $error("accepted interrupt did not reach its vector");
	a_req_set: assert property (
		(|reqSet) |=> ((req_r & $past(reqSet)) == $past(reqSet)))
		else $error("request flag lost");
	a_di_clear: assert property (
		isDi |=> !mie_r ##1 (mode_r != MODE_VECTOR || $past(mie_r)))
		else $error("disable did not clear the master enable");
	a_stop_clk: assert property (
		isStop |=> (mode_r == MODE_STOP) && clkStop_r && !ready_r)
		else $error("stop did not gate the clock");
	a_halt_wait: assert property (
		(mode_r == MODE_HALT && !released) |=> (mode_r == MODE_HALT) && !ready_r)
		else $error("halt left without its release condition");
	a_nop_step: assert property (
		isNop |=> (pc_r == $past(pc_r) + 10'h001) && (sp_r == $past(sp_r)) && $stable(flag_r))
		else $error("no-op changed more than the program counter");

endmodule : sico_ctrl

// ### src/sico_cfg.svh
/*
 * offsets, field positions, reset values, opcodes and vector addresses
 * of the subroutine / interrupt control unit.
 * assumes it is included by the package, the design modules and the bench.
 */
`ifndef SICO_CFG_SVH
`define SICO_CFG_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define SICO_PC_W 10
`define SICO_SP_W 3
`define SICO_ISP_W 2
`define SICO_FLAG_W 4
`define SICO_SRC_N 3

// ----------------------------------------------------------------
// register byte offsets on the slave bus
// ----------------------------------------------------------------
`define SICO_OFS_JBASE 4'h0
`define SICO_OFS_IRQ 4'h4
`define SICO_OFS_FLAG 4'h8
`define SICO_OFS_STAT 4'hc

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SICO_IRQ_REQ_LSB 8
`define SICO_STAT_SP_LSB 12
`define SICO_STAT_MIE_BIT 16
`define SICO_STAT_MODE_LSB 17
`define SICO_STAT_COND_LSB 20

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SICO_PC_RST 10'h000
`define SICO_SP_RST 3'h0
`define SICO_ISP_RST 2'h0
`define SICO_FLAG_RST 4'h0
`define SICO_JBASE_RST 10'h000
`define SICO_SRCEN_RST 3'h0
`define SICO_COND_RST 4'h0

// ----------------------------------------------------------------
// instruction codes
// ----------------------------------------------------------------
`define SICO_OP_BR_AR 16'h3840
`define SICO_OP_CALL_AR 16'h3850
`define SICO_OP_RET 16'h38e0
`define SICO_OP_SUBR_EXIT_SKIP_OP 16'h39e0
`define SICO_OP_ISR_EXIT_OP 16'h3ce0
`define SICO_OP_EI 16'h38f0
`define SICO_OP_DI 16'h39f0
`define SICO_OP_NOP 16'h3cf0
`define SICO_OP_STOP_HI 12'h3af
`define SICO_OP_HALT_HI 12'h3bf

// ----------------------------------------------------------------
// vector addresses, one per source, lowest source wins
// ----------------------------------------------------------------
`define SICO_VEC0 10'h001
`define SICO_VEC1 10'h002
`define SICO_VEC2 10'h003

`endif

// ### src/sico_pkg.sv
/*
 * types shared by the subroutine / interrupt control unit.
 * assumes sico_cfg.svh is on the include path.
 */
`include "sico_cfg.svh"

package sico_pkg;

	// ----------------------------------------------------------------
	// core power / sequencing mode
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_RUN = 2'h0,
		MODE_VECTOR = 2'h1,
		MODE_HALT = 2'h2,
		MODE_STOP = 2'h3
	} sico_mode_type;

	// one instruction offered by the fetch stage
	typedef struct packed {
		logic valid;
		logic [15:0] word;
	} sico_instr_type;

	// avalon-mm request from the master
	typedef struct packed {
		logic read;
		logic write;
		logic [3:0] address;
		logic [31:0] writedata;
	} sico_avs_req_type;

endpackage : sico_pkg

// ### src/sico_lifo.sv
/*
 * small stack memory: one synchronous write port, one combinational
 * read port, addressed by the owner's pointer.
 * assumes the owner keeps the pointer; contents are not reset.
 */
`timescale 1ns/1ps

module sico_lifo #(
	parameter int W = 10,
	parameter int AW = 3
) (
	input wire logic clk,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [W-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [W-1:0] rdata
);

	logic [W-1:0] mem [0:(1<<AW)-1];

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// read of the slot the pointer names
	assign rdata = mem[raddr];

endmodule : sico_lifo

// ### sim/tb_sico_ctrl.sv
/*
 * self-checking bench of the subroutine / interrupt control unit.
 * assumes sico_cfg.svh on the include path and sico_pkg compiled first.
 */
`timescale 1ns/1ps
`include "sico_cfg.svh"

// compare two values, count it, report a mismatch
`define CHK(g, e) chk(32'(g), 32'(e))

module tb_sico_ctrl
	import sico_pkg::*;
;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic clk;
	logic nrst;
	sico_instr_type instr;
	logic [2:0] irqPin;
	logic wakePin;
	sico_avs_req_type avsReq;
	logic [31:0] avsReaddata;
	logic avsWaitrequest;
	logic instrReady;
	logic [9:0] programCounter;
	logic [2:0] stackPtr;
	logic masterIrqEnable;
	logic [3:0] flagWord;
	sico_mode_type powerMode;
	logic sysClkStop;
	logic readyHalf;
	logic waitHalf;
	logic [31:0] rdHalf;
	logic [31:0] q;
	int errTotal;
	int checkCount;
	int cyc;

	sico_ctrl dut (
		.clk(clk),
		.nrst(nrst),
		.instr(instr),
		.irqPin(irqPin),
		.wakePin(wakePin),
		.avsReq(avsReq),
		.avsReaddata(avsReaddata),
		.avsWaitrequest(avsWaitrequest),
		.instrReady(instrReady),
		.programCounter(programCounter),
		.stackPtr(stackPtr),
		.masterIrqEnable(masterIrqEnable),
		.flagWord(flagWord),
		.powerMode(powerMode),
		.sysClkStop(sysClkStop)
	);

	// ----------------------------------------------------------------
	// clock, mid-cycle samples, timeout
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// values held across the next rising edge, free of edge races
	always @(negedge clk) begin
		readyHalf = instrReady;
		waitHalf = avsWaitrequest;
		rdHalf = avsReaddata;
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			errTotal++;
			closeOut();
		end
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checkCount++;
		if (got !== exp) begin
			errTotal++;
			$display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic closeOut();
		if (errTotal == 0 && checkCount > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : closeOut

	// one avalon access, held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		avsReq <= '{read: !wr, write: wr, address: a, writedata: d};
		do begin
			@(posedge clk);
			n++;
		end while (waitHalf !== 1'b0 && n < 50);
		q = rdHalf;
		avsReq <= '0;
		if (n >= 50) `CHK(1'b0, 1'b1);
		@(negedge clk);
	endtask : bus

	// one instruction, held until the core takes it
	task automatic op(input logic [15:0] w);
		int n;
		n = 0;
		@(posedge clk);
		instr <= '{valid: 1'b1, word: w};
		do begin
			@(posedge clk);
			n++;
		end while (readyHalf !== 1'b1 && n < 50);
		instr <= '0;
		if (n >= 50) `CHK(1'b0, 1'b1);
		@(negedge clk);
	endtask : op

	// bounded wait for the core to reach a state
	task automatic waitPc(input logic [9:0] t);
		for (int i = 0; i < 30 && programCounter !== t; i++) @(negedge clk);
	endtask : waitPc

	task automatic waitRun();
		for (int i = 0; i < 30 && powerMode !== MODE_RUN; i++) @(negedge clk);
	endtask : waitRun

	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask : idle

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		nrst = 1'b0;
		instr = '0;
		irqPin = 3'h0;
		wakePin = 1'b0;
		avsReq = '0;
		errTotal = 0;
		checkCount = 0;
		cyc = 0;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		idle(2);
		`CHK(programCounter, 10'h000);
		`CHK(stackPtr, 3'h0);
		`CHK(masterIrqEnable, 1'b0);
		`CHK(powerMode, MODE_RUN);
		`CHK(sysClkStop, 1'b0);
		`CHK({avsWaitrequest, instrReady, flagWord}, {1'b1, 1'b1, 4'h0});
		// jump base keeps only its lower ten bits
		bus(1'b1, `SICO_OFS_JBASE, 32'hffff_fc20);
		bus(1'b0, `SICO_OFS_JBASE, 32'h0000_0000);
		`CHK(q, 32'h0000_0020);
		bus(1'b0, 4'h6, 32'h0000_0000);
		`CHK(q, 32'h0000_0000);
		bus(1'b1, `SICO_OFS_FLAG, 32'h0000_000a);
		`CHK(flagWord, 4'ha);
		op(`SICO_OP_NOP);
		`CHK({programCounter, stackPtr, masterIrqEnable, flagWord}, {10'h001, 3'h0, 1'b0, 4'ha});
		op(`SICO_OP_CALL_AR);
		`CHK({programCounter, stackPtr}, {10'h020, 3'h7});
		op(`SICO_OP_NOP);
		op(`SICO_OP_RET);
		`CHK({programCounter, stackPtr}, {10'h002, 3'h0});
		op(`SICO_OP_CALL_AR);
		`CHK(programCounter, 10'h020);
		op(`SICO_OP_SUBR_EXIT_SKIP_OP);
		`CHK({programCounter, stackPtr}, {10'h004, 3'h0});
		// a masked source still raises its flag without diverting flow
		op(`SICO_OP_EI);
		`CHK({programCounter, masterIrqEnable}, {10'h005, 1'b1});
		op(`SICO_OP_NOP);
		irqPin <= 3'h2;
		idle(10);
		`CHK(programCounter, 10'h006);
		bus(1'b0, `SICO_OFS_IRQ, 32'h0000_0000);
		`CHK(q, 32'h0000_0200);
		op(`SICO_OP_DI);
		`CHK({programCounter, masterIrqEnable}, {10'h007, 1'b0});
		bus(1'b1, `SICO_OFS_IRQ, 32'h0000_0002);
		idle(10);
		`CHK(programCounter, 10'h007);
		// enable waits for one more instruction, then vectors
		op(`SICO_OP_EI);
		idle(5);
		`CHK(programCounter, 10'h008);
		op(`SICO_OP_NOP);
		waitPc(`SICO_VEC1);
		`CHK({programCounter, stackPtr, masterIrqEnable}, {`SICO_VEC1, 3'h7, 1'b0});
		irqPin <= 3'h0;
		bus(1'b0, `SICO_OFS_IRQ, 32'h0000_0000);
		`CHK(q, 32'h0000_0002);
		// interrupt return from a plain call in the service routine still pops the save stack
		bus(1'b1, `SICO_OFS_FLAG, 32'h0000_0005);
		`CHK(flagWord, 4'h5);
		op(`SICO_OP_CALL_AR);
		op(`SICO_OP_ISR_EXIT_OP);
		`CHK({programCounter, stackPtr, flagWord}, {10'h003, 3'h7, 4'ha});
		op(`SICO_OP_RET);
		`CHK({programCounter, stackPtr}, {10'h009, 3'h0});
		// halt and stop, released by the wake input
		op({`SICO_OP_HALT_HI, 4'h8});
		idle(2);
		`CHK({powerMode, instrReady}, {MODE_HALT, 1'b0});
		wakePin <= 1'b1;
		waitRun();
		`CHK(powerMode, MODE_RUN);
		wakePin <= 1'b0;
		idle(4);
		op({`SICO_OP_STOP_HI, 4'h8});
		idle(2);
		`CHK({powerMode, sysClkStop, instrReady}, {MODE_STOP, 1'b1, 1'b0});
		wakePin <= 1'b1;
		waitRun();
		`CHK({powerMode, sysClkStop}, {MODE_RUN, 1'b0});
		wakePin <= 1'b0;
		bus(1'b0, `SICO_OFS_STAT, 32'h0000_0000);
		`CHK(q, 32'h0080_000b);
		op(`SICO_OP_BR_AR);
		`CHK({programCounter, stackPtr}, {10'h020, 3'h0});
		idle(4);
		closeOut();
	end

endmodule : tb_sico_ctrl
